// [glrc_cmd_dec.sv]
// Decoder of interface messages received while ATN is true
`timescale 1ns/1ns
module glrc_cmd_dec
  import glrc_pkg::*;
(
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic [4:0] my_addr,
  output logic is_gtl,
  output logic is_sdc,
  output logic is_get,
  output logic is_llo,
  output logic is_dcl,
  output logic is_spe,
  output logic is_spd,
  output logic is_mla,
  output logic is_mta,
  output logic is_unl,
  output logic is_unt
);
  // Parity bit is ignored on the message lines
  wire [6:0] msg = cmd_byte[6:0];
  // Address group and address field of the message
  wire [1:0] grp = msg[6:5];
  wire addr_hit = (msg[4:0] == my_addr);

  assign is_gtl = cmd_valid && (msg == MSG_GTL);
  assign is_sdc = cmd_valid && (msg == MSG_SDC);
  assign is_get = cmd_valid && (msg == MSG_GET);
  assign is_llo = cmd_valid && (msg == MSG_LLO);
  assign is_dcl = cmd_valid && (msg == MSG_DCL);
  assign is_spe = cmd_valid && (msg == MSG_SPE);
  assign is_spd = cmd_valid && (msg == MSG_SPD);
  assign is_unl = cmd_valid && (msg == MSG_UNL);
  assign is_unt = cmd_valid && (msg == MSG_UNT);
  // Own address only; 31 is the unaddress code and never matches
  assign is_mla = cmd_valid && (grp == GRP_LISTEN) && addr_hit;
  assign is_mta = cmd_valid && (grp == GRP_TALK) && addr_hit;
endmodule : glrc_cmd_dec

// [glrc_ctl_model.sv]
// Bus controller model: drives REN, IFC, commands and poll reads
`timescale 1ns/1ns
module glrc_ctl_model
#(
  parameter int IFC_CYCLES = 10000
)
(
  input wire logic hclk,
  output logic ren,
  output logic ifc,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic poll_taken
);
  // Controller address, kept apart from any device address
  localparam logic [4:0] OWN_ADDR = 5'h15;
  // Idle bus at time zero
  initial
  begin
    ren = 1'b0;
    ifc = 1'b0;
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    poll_taken = 1'b0;
  end
  // One message; the byte is scrambled after, so stale data never helps
  task send(input logic [7:0] c);
    @(posedge hclk);
    cmd_valid <= 1'b1;
    cmd_byte <= c;
    @(posedge hclk);
    cmd_valid <= 1'b0;
    cmd_byte <= ~c;
  endtask : send
  // Remote enable line level
  task set_ren(input logic v);
    @(posedge hclk);
    ren <= v;
  endtask : set_ren
  // Interface clear held the full minimum time (100 us at 100 MHz)
  task clear_bus();
    @(posedge hclk);
    ifc <= 1'b1;
    repeat (IFC_CYCLES) @(posedge hclk);
    ifc <= 1'b0;
  endtask : clear_bus
  // Controller takes the talker byte once
  task take_poll();
    @(posedge hclk);
    poll_taken <= 1'b1;
    @(posedge hclk);
    poll_taken <= 1'b0;
  endtask : take_poll
endmodule : glrc_ctl_model

// [glrc_pkg.sv]
// Package of constants and types for the bus remote/local control block
// Contract
// - Address 0..30; respond only to matching address
// - Primary address defaults to 16
// - Show address on display after power-up
// - REN alone never enters remote
// - Talking allowed in local or remote
// - In remote only local key works
// - Local key returns to local unless lockout
// - IFC forces local, talker idle, listener idle
// - IFC turns off talk and listen lamps
// - IFC leaves settings and events untouched; the code sets the IFC event and, on leaving remote, the remote event
// - Lockout disables all keys including local
// - GTL or REN drop leaves remote
// - DCL, or SDC when addressed, clears interface; the code pulses dev_clear, ends poll mode, keeps talker and listener
// - Serial poll returns status byte
// - GET triggers only if bus trigger selected
// - Listener/talker idle on UNL/UNT/cross address
package glrc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATE = 8'h04;
  localparam logic [7:0] OFS_EVENT = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  localparam logic [7:0] OFS_SPOLL = 8'h10;
  // Control register fields
  localparam int CTRL_ADDR_LSB = 0;
  localparam int CTRL_TRIG_BIT = 8;
  localparam int CTRL_RQS_BIT = 9;
  // Address limits and reset value
  localparam logic [4:0] ADDR_MAX = 5'h1E;
  localparam logic [4:0] ADDR_RESET = 5'h10;
  // Event bit positions
  localparam int EV_IFC = 0;
  localparam int EV_CLEAR = 1;
  localparam int EV_TRIG = 2;
  localparam int EV_LLO = 3;
  localparam int EV_REMOTE = 4;
  localparam int EV_POLLED = 5;
  localparam int EV_W = 6;
  // Multiline interface messages, parity bit dropped
  localparam logic [6:0] MSG_GTL = 7'h01;
  localparam logic [6:0] MSG_SDC = 7'h04;
  localparam logic [6:0] MSG_GET = 7'h08;
  localparam logic [6:0] MSG_LLO = 7'h11;
  localparam logic [6:0] MSG_DCL = 7'h14;
  localparam logic [6:0] MSG_SPE = 7'h18;
  localparam logic [6:0] MSG_SPD = 7'h19;
  localparam logic [6:0] MSG_UNL = 7'h3F;
  localparam logic [6:0] MSG_UNT = 7'h5F;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;
  // Power-up address display time
  localparam int SHOW_TIME_MS = 1000;
  localparam int CLK_KHZ = 100000;
  localparam int SHOW_CYCLES = SHOW_TIME_MS * CLK_KHZ;
  // Remote/local states, one-hot
  typedef enum logic [3:0] {
    RL_LOCAL = 4'b0001,
    RL_REMOTE = 4'b0010,
    RL_LOCAL_LOCK = 4'b0100,
    RL_REMOTE_LOCK = 4'b1000
  } glrc_rl_t;
endpackage : glrc_pkg

// [glrc_timer.sv]
// One-shot timer that holds its output for a set number of cycles
`timescale 1ns/1ns
module glrc_timer
#(
  parameter int COUNT = 16
)
(
  input wire logic hclk,
  input wire logic hresetn,
  output logic busy
);
  localparam int CW = $clog2(COUNT + 1);
  // Remaining cycles; loaded at reset so the window opens at power-up
  logic [CW-1:0] cnt_q;

  // Count down to zero, then rest
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_q <= CW'(COUNT);
    else if (cnt_q != '0)
      cnt_q <= cnt_q - 1'b1;
  end

  assign busy = (cnt_q != '0);
endmodule : glrc_timer

// [glrc_top.sv]
// Bus remote/local, addressing, clear, trigger and poll control with AHB regs
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module glrc_top
  import glrc_pkg::*;
#(
  parameter int SHOW_COUNT = SHOW_CYCLES
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ren,
  input wire logic ifc,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic poll_taken,
  input wire logic key_press,
  input wire logic key_is_local,
  output logic remote_indicator,
  output logic talk_indicator,
  output logic listen_indicator,
  output logic srq_indicator,
  output logic lockout,
  output logic key_accept,
  output logic show_addr,
  output logic [4:0] primary_addr,
  output logic spoll_active,
  output logic [7:0] spoll_byte,
  output logic trigger,
  output logic dev_clear,
  output logic irq
);
  import glrc_pkg::*;

  // Register state
  logic [4:0] addr_q; // Primary bus address
  logic trig_src_q; // Bus trigger selected as control source
  logic rqs_q; // Service request pending
  logic [5:0] sbyte_q; // Status byte bits below RQS; bit 6 is RQS itself
  logic [EV_W-1:0] ev_q;
  logic [EV_W-1:0] ev_d;
  logic [EV_W-1:0] mask_q;
  // Interface state
  glrc_rl_t rl_q;
  glrc_rl_t rl_d;
  logic talk_q;
  logic listen_q;
  logic spm_q; // Serial poll mode
  logic key_q;
  logic trig_q;
  logic clr_q;
  logic show_q;
  logic irq_q;
  logic [31:0] rdata_q;
  logic ready_q;
  // Captured AHB address phase
  logic wr_q;
  logic [7:0] wa_q;

  // Message decode
  wire m_gtl, m_sdc, m_get, m_llo, m_dcl, m_spe, m_spd;
  wire m_mla, m_mta, m_unl, m_unt;
  glrc_cmd_dec u_dec (
    .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte),
    .my_addr(addr_q),
    .is_gtl(m_gtl),
    .is_sdc(m_sdc),
    .is_get(m_get),
    .is_llo(m_llo),
    .is_dcl(m_dcl),
    .is_spe(m_spe),
    .is_spd(m_spd),
    .is_mla(m_mla),
    .is_mta(m_mta),
    .is_unl(m_unl),
    .is_unt(m_unt)
  );

  // Power-up window during which the address is shown
  wire show_busy;
  glrc_timer #(.COUNT(SHOW_COUNT)) u_show (
    .hclk(hclk),
    .hresetn(hresetn),
    .busy(show_busy)
  );

  // Addressed commands count only while we are a listener
  wire gtl_hit = m_gtl && listen_q;
  wire clear_hit = m_dcl || (m_sdc && listen_q);
  wire get_hit = m_get && listen_q;
  wire trig_hit = get_hit && trig_src_q;
  wire is_remote = rl_q inside {RL_REMOTE, RL_REMOTE_LOCK};
  wire is_locked = rl_q inside {RL_LOCAL_LOCK, RL_REMOTE_LOCK};
  // Local key works only in plain remote, never under lockout
  wire local_key = key_press && key_is_local && (rl_q == RL_REMOTE);
  // Remote swallows every key but the local key
  wire key_ok = key_press && !is_remote && !is_locked;
  wire polled = poll_taken && spm_q && talk_q;

  // Remote/local state choice; REN drop and IFC take priority
  always_comb
  begin
    rl_d = rl_q;
    if (!ren)
      rl_d = RL_LOCAL;
    else if (ifc)
      rl_d = is_locked ? RL_LOCAL_LOCK : RL_LOCAL;
    else
    begin
      unique case (rl_q)
        RL_LOCAL:
        begin
          // REN by itself is not enough; a listen address is needed
          if (m_mla)
            rl_d = RL_REMOTE;
          else if (m_llo)
            rl_d = RL_LOCAL_LOCK;
        end
        RL_LOCAL_LOCK:
        begin
          if (m_mla)
            rl_d = RL_REMOTE_LOCK;
        end
        RL_REMOTE:
        begin
          if (gtl_hit || local_key)
            rl_d = RL_LOCAL;
          else if (m_llo)
            rl_d = RL_REMOTE_LOCK;
        end
        RL_REMOTE_LOCK:
        begin
          // Local key has no effect here; besides REN drop and IFC, only GTL leaves remote.
          // GTL also lifts the lockout, otherwise the keys stay dead
          if (gtl_hit)
            rl_d = RL_LOCAL;
        end
        default:
          rl_d = RL_LOCAL;
      endcase
    end
  end

  // Events; a new event in the read-clear cycle is kept
  wire ev_rd = hsel && htrans[1] && !hwrite && hready
    && (haddr == OFS_EVENT);
  wire [EV_W-1:0] ev_set;
  assign ev_set[EV_IFC] = ifc;
  assign ev_set[EV_CLEAR] = clear_hit;
  assign ev_set[EV_TRIG] = trig_hit;
  assign ev_set[EV_LLO] = m_llo;
  assign ev_set[EV_REMOTE] = is_remote != (rl_d inside
    {RL_REMOTE, RL_REMOTE_LOCK});
  assign ev_set[EV_POLLED] = polled;
  assign ev_d = (ev_rd ? '0 : ev_q) | ev_set;

  // Read mux for the address phase; data is registered for the next cycle
  wire [31:0] ctrl_v = {22'h0, rqs_q, trig_src_q, 3'h0, addr_q};
  wire [31:0] state_v = {24'h0, show_q, spm_q, listen_q, talk_q,
    is_locked, is_remote, 2'h0};
  wire [31:0] rd_mux =
    (haddr == OFS_CTRL) ? ctrl_v :
    (haddr == OFS_STATE) ? state_v :
    (haddr == OFS_EVENT) ? {26'h0, ev_q} :
    (haddr == OFS_MASK) ? {26'h0, mask_q} :
    (haddr == OFS_SPOLL) ? {24'h0, spoll_byte} : 32'h0;
  wire rd_go = hsel && htrans[1] && !hwrite && hready;
  wire wr_go = hsel && htrans[1] && hwrite && hready;
  // Out-of-range addresses are dropped, the old value stays
  wire [4:0] wr_addr = hwdata[CTRL_ADDR_LSB +: 5];
  wire addr_ok = wr_addr <= ADDR_MAX;
  wire wr_ctrl = wr_q && (wa_q == OFS_CTRL);
  wire wr_mask = wr_q && (wa_q == OFS_MASK);
  wire wr_spoll = wr_q && (wa_q == OFS_SPOLL);

  // AHB address phase capture and read data
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
      ready_q <= 1'b0;
    end
    else
    begin
      wr_q <= wr_go;
      wa_q <= haddr;
      ready_q <= 1'b1;
      if (rd_go)
        rdata_q <= rd_mux;
    end
  end

  // Software settings; IFC and clears never touch these
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_q <= ADDR_RESET;
      trig_src_q <= 1'b0;
      mask_q <= '0;
      sbyte_q <= 6'h00;
    end
    else
    begin
      if (wr_ctrl && addr_ok)
        addr_q <= wr_addr;
      if (wr_ctrl)
        trig_src_q <= hwdata[CTRL_TRIG_BIT];
      if (wr_mask)
        mask_q <= hwdata[EV_W-1:0];
      if (wr_spoll)
        sbyte_q <= hwdata[5:0];
    end
  end

  // Service request: set by software, cleared once the poll byte is read
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rqs_q <= 1'b0;
    else if (wr_ctrl && hwdata[CTRL_RQS_BIT])
      rqs_q <= 1'b1;
    else if (polled || (wr_ctrl && !hwdata[CTRL_RQS_BIT]))
      rqs_q <= 1'b0;
  end

  // Talker and listener: IFC wins, then the address messages
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      talk_q <= 1'b0;
      listen_q <= 1'b0;
    end
    else if (ifc)
    begin
      talk_q <= 1'b0;
      listen_q <= 1'b0;
    end
    else
    begin
      // Talking does not depend on remote
      if (m_mta)
        talk_q <= 1'b1;
      else if (m_unt || m_mla)
        talk_q <= 1'b0;
      if (m_mla)
        listen_q <= 1'b1;
      else if (m_unl || m_mta)
        listen_q <= 1'b0;
    end
  end

  // Remote state, serial poll mode, pulses and interrupt
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rl_q <= RL_LOCAL;
      spm_q <= 1'b0;
      key_q <= 1'b0;
      trig_q <= 1'b0;
      clr_q <= 1'b0;
      show_q <= 1'b0;
      ev_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      rl_q <= rl_d;
      // Poll mode ends on SPD, on IFC and on a device clear
      if (ifc || m_spd || clear_hit)
        spm_q <= 1'b0;
      else if (m_spe)
        spm_q <= 1'b1;
      key_q <= key_ok || local_key;
      trig_q <= trig_hit;
      clr_q <= clear_hit;
      show_q <= show_busy;
      ev_q <= ev_d;
      irq_q <= |(ev_d & mask_q);
    end
  end

  // Outputs from flip-flops; hresp is tied low
  assign hrdata = rdata_q;
  assign hreadyout = ready_q;
  assign hresp = 1'b0;
  assign remote_indicator = rl_q[1] | rl_q[3];
  assign talk_indicator = talk_q;
  assign listen_indicator = listen_q;
  assign srq_indicator = rqs_q;
  assign lockout = rl_q[2] | rl_q[3];
  assign key_accept = key_q;
  assign show_addr = show_q;
  assign primary_addr = addr_q;
  assign spoll_active = spm_q;
  assign spoll_byte = {1'b0, rqs_q, sbyte_q};
  assign trigger = trig_q;
  assign dev_clear = clr_q;
  assign irq = irq_q;

  // Checks
  sequence s_addr_listen;
    ren && m_mla && !ifc;
  endsequence
  sequence s_enter_remote;
    ##1 remote_indicator;
  endsequence
  a_listen_remote: assert property (@(posedge hclk) disable iff (!hresetn)
    s_addr_listen |-> s_enter_remote)
    else $error("listen address with REN did not give remote");
  a_ren_alone: assert property (@(posedge hclk) disable iff (!hresetn)
    (!remote_indicator && !m_mla) |=> !remote_indicator)
    else $error("remote entered without a listen address");
  a_ifc_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    ifc |=> !talk_indicator && !listen_indicator && !remote_indicator)
    else $error("IFC did not idle the interface");
  a_ifc_keeps: assert property (@(posedge hclk) disable iff (!hresetn)
    (ifc && !wr_ctrl) |=> $stable(primary_addr))
    else $error("IFC changed the address");
  a_ren_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    !ren |=> !remote_indicator && !lockout)
    else $error("REN false left remote or lockout");
  a_key_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    (key_press && remote_indicator) |=> key_accept == ($past(key_is_local)
      && !$past(lockout)))
    else $error("key passed in remote");
  a_lock_key: assert property (@(posedge hclk) disable iff (!hresetn)
    (lockout && remote_indicator && ren && !ifc && !m_gtl)
      |=> remote_indicator)
    else $error("remote left under lockout");
  a_trig_src: assert property (@(posedge hclk) disable iff (!hresetn)
    trigger |-> $past(m_get && listen_q && trig_src_q))
    else $error("trigger without bus trigger source");
  a_addr_range: assert property (@(posedge hclk) disable iff (!hresetn)
    primary_addr <= ADDR_MAX)
    else $error("address above 30");
  a_unl_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    (m_unl || m_mta) && !m_mla |=> !listen_indicator)
    else $error("listener kept after UNL or talk address");
  a_clear_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    m_dcl |=> dev_clear && !spoll_active)
    else $error("DCL not obeyed");
endmodule : glrc_top

// [tb_glrc_top.sv]
// Self-checking bench for the bus remote/local control block
`timescale 1ns/1ns
module tb_glrc_top;
  import glrc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0] haddr, cmd_byte, spoll_byte;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd, v;
  logic [31:0] seed = 32'hBBCB; // Fixed seed, repeatable run
  logic ren, ifc, cmd_valid, poll_taken, key_press, key_is_local;
  logic remote_indicator, talk_indicator, listen_indicator, srq_indicator;
  logic lockout, key_accept, show_addr, spoll_active, trigger, dev_clear;
  logic irq;
  logic [4:0] primary_addr, a, b;
  int errors = 0;
  int samples_checked = 0;
  int n_trig = 0; // Pulse tallies, so latency never matters
  int n_clr = 0;
  int n_key = 0;
  // Single slave: its ready is the bus ready
  assign hready = hreadyout;
  glrc_top #(.SHOW_COUNT(20)) glrc_top_inst (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .ren, .ifc, .cmd_valid, .cmd_byte, .poll_taken, .key_press, .key_is_local,
    .remote_indicator, .talk_indicator, .listen_indicator, .srq_indicator,
    .lockout, .key_accept, .show_addr, .primary_addr, .spoll_active,
    .spoll_byte, .trigger, .dev_clear, .irq);
  glrc_ctl_model ctl (.hclk, .ren, .ifc, .cmd_valid, .cmd_byte, .poll_taken);
  // Clock, 10 ns period
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // Count one-cycle pulses
  always @(posedge hclk)
  begin
    if (trigger === 1'b1) n_trig <= n_trig + 1;
    if (dev_clear === 1'b1) n_clr <= n_clr + 1;
    if (key_accept === 1'b1) n_key <= n_key + 1;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic logic [7:0] mla(input logic [4:0] x);
    return {3'h1, x};
  endfunction : mla
  function automatic logic [7:0] mta(input logic [4:0] x);
    return {3'h2, x};
  endfunction : mta
  // Status byte: bit 6 carries the service request flag
  function automatic logic [7:0] spb(input logic [31:0] x, input logic q);
    return {1'b0, q, x[5:0]};
  endfunction : spb
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      errors++;
    end
  endtask : chk
  // One single AHB transfer; read data lands in rd
  task ahb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= ad;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task cyc(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : cyc
  task tx(input logic [7:0] c);
    ctl.send(c);
    cyc(2);
  endtask : tx
  task key(input logic loc);
    @(posedge hclk);
    key_press <= 1'b1;
    key_is_local <= loc;
    @(posedge hclk);
    key_press <= 1'b0;
    cyc(2);
  endtask : key
  task done(input string n);
    $display("test %s finished", n);
  endtask : done
  task wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  // Watchdog: the run needs about 10200 cycles; 30000 leaves ample margin
  initial
  begin
    #300000;
    errors++;
    wrap_up();
  end
  initial
  begin
    hresetn = 1'b0;
    {hsel, hwrite, key_press, key_is_local} = 4'h0;
    {haddr, htrans, hsize, hwdata} = 45'h0;
    hsize = 3'h2;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    cyc(2);
    chk("show", show_addr, 1'b1);
    chk("addr", primary_addr, 5'h10);
    ahb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", rd, 32'h10);
    chk("resp", hresp, 1'b0);
    ahb(1'b0, 8'h14, 32'h0);
    chk("unmapped", rd, 32'h0);
    cyc(30);
    chk("show", show_addr, 1'b0);
    done("reset");
    a = 5'(xs() % 31);
    if (a == ctl.OWN_ADDR) a = 5'h00;
    b = (a == 5'h1E) ? 5'h00 : a + 5'h01;
    ahb(1'b1, OFS_CTRL, {27'h0, a});
    ahb(1'b1, OFS_CTRL, 32'h1F);
    cyc(2);
    chk("addr", primary_addr, a);
    ctl.set_ren(1'b1);
    cyc(3);
    chk("remote", remote_indicator, 1'b0);
    tx(mla(b));
    chk("listen", listen_indicator, 1'b0);
    tx(mla(a));
    chk("remote", remote_indicator, 1'b1);
    chk("listen", listen_indicator, 1'b1);
    done("address");
    v = n_key;
    key(1'b0);
    chk("keys", n_key - v, 32'h0);
    key(1'b1);
    chk("keys", n_key - v, 32'h1);
    chk("remote", remote_indicator, 1'b0);
    tx(mta(a));
    chk("talk", talk_indicator, 1'b1);
    chk("listen", listen_indicator, 1'b0);
    tx(mla(a));
    chk("talk", talk_indicator, 1'b0);
    tx({1'b0, MSG_UNL});
    chk("listen", listen_indicator, 1'b0);
    tx(mta(a));
    tx({1'b0, MSG_UNT});
    chk("talk", talk_indicator, 1'b0);
    done("keys and roles");
    ahb(1'b1, OFS_MASK, 32'h1 << EV_IFC);
    ahb(1'b1, OFS_CTRL, 32'h100 | a);
    tx(mla(a));
    ctl.clear_bus();
    cyc(3);
    chk("remote", remote_indicator, 1'b0);
    chk("lamps", {talk_indicator, listen_indicator}, 2'h0);
    chk("irq", irq, 1'b1);
    ahb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", rd, 32'h100 | a);
    ahb(1'b0, OFS_EVENT, 32'h0);
    chk("ifc event", rd[EV_IFC], 1'b1);
    cyc(3);
    chk("irq", irq, 1'b0);
    done("interface clear");
    v = n_trig;
    tx(mla(a));
    tx({1'b0, MSG_GET});
    chk("trig", n_trig - v, 32'h1);
    ahb(1'b1, OFS_CTRL, {27'h0, a});
    tx({1'b0, MSG_GET});
    chk("trig", n_trig - v, 32'h1);
    v = n_clr;
    tx({1'b0, MSG_DCL});
    tx({1'b0, MSG_SDC});
    tx({1'b0, MSG_UNL});
    tx({1'b0, MSG_SDC});
    chk("clear", n_clr - v, 32'h2);
    done("trigger and clear");
    v = n_key;
    tx({1'b0, MSG_LLO});
    tx(mla(a));
    chk("lockout", lockout, 1'b1);
    key(1'b1);
    chk("keys", n_key - v, 32'h0);
    chk("remote", remote_indicator, 1'b1);
    tx({1'b0, MSG_GTL});
    chk("remote", remote_indicator, 1'b0);
    key(1'b0);
    chk("keys", n_key - v, 32'h1);
    chk("lockout", lockout, 1'b0);
    tx({1'b0, MSG_LLO});
    chk("lockout", lockout, 1'b1);
    chk("remote", remote_indicator, 1'b0);
    key(1'b0);
    chk("keys", n_key - v, 32'h1);
    ctl.set_ren(1'b0);
    cyc(3);
    chk("lockout", lockout, 1'b0);
    done("lockout");
    v = xs();
    ahb(1'b1, OFS_SPOLL, v);
    ahb(1'b1, OFS_CTRL, 32'h200 | a);
    tx({1'b0, MSG_SPE});
    tx(mta(a));
    chk("spoll", spoll_active, 1'b1);
    chk("talk", talk_indicator, 1'b1);
    chk("sbyte", spoll_byte, spb(v, 1'b1));
    chk("srq", srq_indicator, 1'b1);
    ctl.take_poll();
    cyc(3);
    chk("sbyte", spoll_byte, spb(v, 1'b0));
    chk("srq", srq_indicator, 1'b0);
    ahb(1'b0, OFS_EVENT, 32'h0);
    chk("polled", rd[EV_POLLED], 1'b1);
    tx({1'b0, MSG_SPD});
    chk("spoll", spoll_active, 1'b0);
    done("serial poll");
    wrap_up();
  end
endmodule : tb_glrc_top
